// ==== ctw_map.vh ====
`ifndef CTW_MAP_VH
`define CTW_MAP_VH
`define CTW_ADDR_TRX_CTRL 7'h20
`define CTW_ADDR_TRX_STAT 7'h22
`define CTW_ADDR_BUS_FAIL 7'h33
`define CTW_ADDR_EVT_STAT2 7'h35
`define CTW_ADDR_WAKE_LVL 7'h4B
`define CTW_ADDR_WAKE_EN 7'h4C
`define CTW_ADDR_PNCFG_LO 7'h26
`define CTW_ADDR_PNCFG_HI 7'h2F
`define CTW_ADDR_PNMASK_LO 7'h68
`define CTW_ADDR_PNMASK_HI 7'h6F
`define CTW_CTRL_MODE_LSB 0
`define CTW_CTRL_SELWAKE_BIT 4
`define CTW_CTRL_CFGOK_BIT 5
`define CTW_CTRL_FDIGN_BIT 6
`define CTW_MODE_RESET 2'h1
`define CTW_SELWAKE_RESET 1'h0
`define CTW_CFGOK_RESET 1'h0
`define CTW_FDIGN_RESET 1'h1
`define CTW_TRXMODE_STBY 2'h0
`define CTW_TRXMODE_NORM_UV 2'h1
`define CTW_TRXMODE_NORM 2'h2
`define CTW_TRXMODE_SILENT 2'h3
`define CTW_DEV_STANDBY 3'h4
`define CTW_DEV_SLEEP 3'h1
`define CTW_DEV_NORMAL 3'h7
`define CTW_WAKE_FALL_BIT 0
`define CTW_WAKE_RISE_BIT 1
`define CTW_WAKE_LVL_BIT 1
`define CTW_SYNC_W 13
`define CTW_SYNC_RESET 13'h0004
`define CTW_WAKE_SETTLE_NS 50000
`define CTW_CLK_MHZ 50
// settle time in mclk cycles at the counter's width: 50 us at 50 MHz
`define CTW_WAKE_SETTLE_CYC 12'h9C4
`define CTW_WCNT_W 12
`endif

// ==== ctw_wake_filter.v ====
`include "ctw_map.vh"

module ctw_wake_filter (
    input wire i_mclk,
    input wire i_rst,
    input wire i_level,
    output reg o_stable,
    output reg o_rise,
    output reg o_fall
);
    localparam [`CTW_WCNT_W-1:0] SETTLE = `CTW_WAKE_SETTLE_CYC;

    reg last_r;
    reg valid_r;
    reg [`CTW_WCNT_W-1:0] cnt_r;

    // count cycles the sampled level has held; a new level is accepted only
    // after it held the full settle time, and the accepted level itself was
    // accepted the same way, so both sides of the edge were stable
    always @(posedge i_mclk) begin
        if (i_rst) begin
            last_r <= 1'b0;
            valid_r <= 1'b0;
            cnt_r <= {`CTW_WCNT_W{1'b0}};
            o_stable <= 1'b0;
            o_rise <= 1'b0;
            o_fall <= 1'b0;
        end else begin
            last_r <= i_level;
            o_rise <= 1'b0;
            o_fall <= 1'b0;
            if (i_level != last_r) begin
                cnt_r <= {`CTW_WCNT_W{1'b0}};
            end else if (cnt_r != SETTLE) begin
                cnt_r <= cnt_r + 1'b1;
            end
            if (i_level == last_r && cnt_r == SETTLE - 1'b1 &&
                (!valid_r || i_level != o_stable)) begin
                o_stable <= i_level;
                valid_r <= 1'b1;
                // first acceptance after reset has no prior level: no edge
                o_rise <= valid_r & i_level;
                o_fall <= valid_r & ~i_level;
            end
        end
    end
endmodule // ctw_wake_filter

// ==== ctw_trx_ctrl.v ====
`include "ctw_map.vh"

module ctw_trx_ctrl (
    input wire i_mclk,
    input wire i_rst,
    input wire i_spi_sck,
    input wire i_spi_cs_n,
    input wire i_spi_sdi,
    input wire [2:0] i_dev_mode,
    input wire i_rx_clamp_evt_en,
    input wire i_tx_ready,
    input wire i_osc_ok,
    input wire i_bus_silent,
    input wire i_vcc_uv,
    input wire i_txd_timeout,
    input wire i_bus_dom_timeout,
    input wire i_bus_short,
    input wire i_rx_clamp_det,
    input wire i_rxd_dominant,
    input wire i_frame_err_wake,
    input wire i_osc_fail,
    input wire i_vio_ok,
    input wire i_txd_low,
    input wire i_wake_pin,
    output reg o_spi_sdo,
    output reg o_spi_sdo_oe,
    output reg o_trx_tx_en,
    output reg o_trx_rx_en,
    output reg o_trx_bias_stby,
    output reg o_fd_frame_ignore,
    output reg o_selective_wake_enable,
    output reg o_selwake_config_valid,
    output reg o_local_wake,
    output reg o_wake_pull_up
);
    // selwake configuration registers live elsewhere but share this port
    function is_pn_cfg;
        input [6:0] a;
        begin
            is_pn_cfg = (a >= `CTW_ADDR_PNCFG_LO && a <= `CTW_ADDR_PNCFG_HI)
                || (a >= `CTW_ADDR_PNMASK_LO && a <= `CTW_ADDR_PNMASK_HI);
        end
    endfunction

    // synchronisers for spi pins and analog status
    reg [2:0] spi_s1_r;
    reg [2:0] spi_s2_r;
    reg [`CTW_SYNC_W-1:0] st_s1_r;
    reg [`CTW_SYNC_W-1:0] st_s2_r;
    reg wake_s1_r;
    reg wake_s2_r;

    always @(posedge i_mclk) begin
        if (i_rst) begin
            spi_s1_r <= 3'h2;
            spi_s2_r <= 3'h2;
            st_s1_r <= `CTW_SYNC_RESET;
            st_s2_r <= `CTW_SYNC_RESET;
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
        end else begin
            spi_s1_r <= {i_spi_sck, i_spi_cs_n, i_spi_sdi};
            spi_s2_r <= spi_s1_r;
            st_s1_r <= {i_txd_low, i_vio_ok, i_osc_fail, i_frame_err_wake,
                        i_rxd_dominant, i_rx_clamp_det, i_bus_short,
                        i_bus_dom_timeout, i_txd_timeout, i_vcc_uv,
                        i_bus_silent, i_osc_ok, i_tx_ready};
            st_s2_r <= st_s1_r;
            wake_s1_r <= i_wake_pin;
            wake_s2_r <= wake_s1_r;
        end
    end

    wire sck = spi_s2_r[2];
    wire cs_n = spi_s2_r[1];
    wire sdi = spi_s2_r[0];
    wire tx_ready = st_s2_r[0];
    wire osc_ok = st_s2_r[1];
    wire bus_silent = st_s2_r[2];
    wire vcc_uv = st_s2_r[3];
    wire txd_to = st_s2_r[4];
    wire bus_dom_to = st_s2_r[5];
    wire bus_short = st_s2_r[6];
    wire clamp_det = st_s2_r[7];
    wire rxd_dom = st_s2_r[8];
    wire frame_err = st_s2_r[9];
    wire osc_fail = st_s2_r[10];
    wire vio_ok = st_s2_r[11];
    wire txd_low = st_s2_r[12];

    // registers
    reg [1:0] trx_mode_select_r;
    reg sck_d_r;
    reg [4:0] bit_cnt_r;
    reg [14:0] rx_sh_r;
    reg [6:0] tx_sh_r;
    reg [1:0] wake_en_r;
    reg rx_clamp_status_r;
    reg [2:0] dev_mode_d_r;
    reg txd_hold_r;
    reg norm_req_d_r;

    wire sck_rise = sck & ~sck_d_r;
    wire sck_fall = ~sck & sck_d_r;
    wire [15:0] frame = {rx_sh_r, sdi};
    wire wr_done = sck_rise && !cs_n && bit_cnt_r == 5'd15 && !frame[8];
    wire [6:0] wr_addr = frame[15:9];
    wire [7:0] wr_data = frame[7:0];
    wire dev_normal = (i_dev_mode == `CTW_DEV_NORMAL);
    wire dev_low = (i_dev_mode == `CTW_DEV_STANDBY) ||
                   (i_dev_mode == `CTW_DEV_SLEEP);

    // read data of the addressed register; unmapped reads return zero
    reg [7:0] rd_data;
    always @* begin
        rd_data = 8'h00;
        case (rx_sh_r[7:1])
            `CTW_ADDR_TRX_CTRL: begin
                rd_data[`CTW_CTRL_MODE_LSB+1:`CTW_CTRL_MODE_LSB] =
                    trx_mode_select_r;
                rd_data[`CTW_CTRL_SELWAKE_BIT] = o_selective_wake_enable;
                rd_data[`CTW_CTRL_CFGOK_BIT] = o_selwake_config_valid;
                rd_data[`CTW_CTRL_FDIGN_BIT] = o_fd_frame_ignore;
            end
            `CTW_ADDR_TRX_STAT: begin
                rd_data[7] = tx_ready;
                rd_data[6] = frame_err | ~o_selwake_config_valid |
                             osc_fail;
                rd_data[5] = o_selwake_config_valid;
                rd_data[4] = osc_ok;
                rd_data[3] = bus_silent;
                rd_data[1] = vcc_uv;
                rd_data[0] = txd_to;
            end
            `CTW_ADDR_BUS_FAIL: begin
                rd_data[1] = bus_dom_to;
                rd_data[0] = bus_short;
            end
            `CTW_ADDR_EVT_STAT2: begin
                rd_data[0] = rx_clamp_status_r;
            end
            `CTW_ADDR_WAKE_LVL: begin
                // level only meaningful with interface supply present
                rd_data[`CTW_WAKE_LVL_BIT] = wake_s2_r & vio_ok &
                    (dev_normal | (|wake_en_r));
            end
            `CTW_ADDR_WAKE_EN: begin
                rd_data[1:0] = wake_en_r;
            end
            default: begin
                rd_data = 8'h00;
            end
        endcase
    end

    // spi slave, mode 0, 16-bit frame: 7-bit address, read flag, data
    always @(posedge i_mclk) begin
        if (i_rst) begin
            sck_d_r <= 1'b0;
            bit_cnt_r <= 5'd0;
            rx_sh_r <= 15'h0000;
            tx_sh_r <= 7'h00;
            o_spi_sdo <= 1'b0;
            o_spi_sdo_oe <= 1'b0;
        end else begin
            sck_d_r <= sck;
            o_spi_sdo_oe <= ~cs_n;
            if (cs_n) begin
                bit_cnt_r <= 5'd0;
                o_spi_sdo <= 1'b0;
            end else if (sck_rise) begin
                rx_sh_r <= {rx_sh_r[13:0], sdi};
                bit_cnt_r <= bit_cnt_r + 5'd1;
            end else if (sck_fall && bit_cnt_r == 5'd8) begin
                // header complete: present the addressed register
                o_spi_sdo <= rd_data[7];
                tx_sh_r <= rd_data[6:0];
            end else if (sck_fall && bit_cnt_r > 5'd8) begin
                o_spi_sdo <= tx_sh_r[6];
                tx_sh_r <= {tx_sh_r[5:0], 1'b0};
            end
        end
    end

    // control and wake-enable registers
    always @(posedge i_mclk) begin
        if (i_rst) begin
            trx_mode_select_r <= `CTW_MODE_RESET;
            o_selective_wake_enable <= `CTW_SELWAKE_RESET;
            o_selwake_config_valid <= `CTW_CFGOK_RESET;
            o_fd_frame_ignore <= `CTW_FDIGN_RESET;
            wake_en_r <= 2'h0;
        end else if (wr_done) begin
            if (wr_addr == `CTW_ADDR_TRX_CTRL) begin
                // only software writes reach the mode field
                trx_mode_select_r <= wr_data[`CTW_CTRL_MODE_LSB+1:
                    `CTW_CTRL_MODE_LSB];
                o_selective_wake_enable <=
                    wr_data[`CTW_CTRL_SELWAKE_BIT];
                o_selwake_config_valid <= wr_data[`CTW_CTRL_CFGOK_BIT];
                o_fd_frame_ignore <= wr_data[`CTW_CTRL_FDIGN_BIT];
            end
            if (wr_addr == `CTW_ADDR_WAKE_EN) begin
                wake_en_r <= wr_data[1:0];
            end
            if (is_pn_cfg(wr_addr)) begin
                o_selwake_config_valid <= 1'b0;
            end
        end
    end

    // receive clamp status: set beats clear in the same cycle
    always @(posedge i_mclk) begin
        if (i_rst) begin
            rx_clamp_status_r <= 1'b0;
            dev_mode_d_r <= `CTW_DEV_STANDBY;
        end else begin
            dev_mode_d_r <= i_dev_mode;
            if (i_rx_clamp_evt_en && clamp_det) begin
                rx_clamp_status_r <= 1'b1;
            end else if (rxd_dom ||
                         (dev_low && i_dev_mode != dev_mode_d_r)) begin
                rx_clamp_status_r <= 1'b0;
            end
        end
    end

    // transceiver steering from the requested mode and live conditions
    wire norm_req = dev_normal &&
        (trx_mode_select_r == `CTW_TRXMODE_NORM_UV ||
         trx_mode_select_r == `CTW_TRXMODE_NORM);
    wire uv_block = (trx_mode_select_r == `CTW_TRXMODE_NORM_UV) &
                    vcc_uv;
    wire txd_hold_nxt = norm_req &&
        ((txd_hold_r || !norm_req_d_r) && txd_low);

    always @(posedge i_mclk) begin
        if (i_rst) begin
            txd_hold_r <= 1'b0;
            norm_req_d_r <= 1'b0;
            o_trx_tx_en <= 1'b0;
            o_trx_rx_en <= 1'b0;
            o_trx_bias_stby <= 1'b0;
        end else begin
            txd_hold_r <= txd_hold_nxt;
            norm_req_d_r <= norm_req;
            if (!dev_normal) begin
                // leaving Normal, incl. undervoltage sleep, biases standby
                o_trx_tx_en <= 1'b0;
                o_trx_rx_en <= 1'b0;
                o_trx_bias_stby <= 1'b1;
            end else if (norm_req) begin
                // mode 10 ignores supply undervoltage entirely
                o_trx_tx_en <= ~uv_block & ~txd_hold_nxt &
                               ~rx_clamp_status_r;
                o_trx_rx_en <= ~uv_block;
                o_trx_bias_stby <= uv_block;
            end else if (trx_mode_select_r == `CTW_TRXMODE_SILENT) begin
                o_trx_tx_en <= 1'b0;
                o_trx_rx_en <= 1'b1;
                o_trx_bias_stby <= 1'b0;
            end else begin
                o_trx_tx_en <= 1'b0;
                o_trx_rx_en <= 1'b0;
                o_trx_bias_stby <= 1'b1;
            end
        end
    end

    // local wake from filtered edges, only in Standby or Sleep
    wire wk_stable;
    wire wk_rise;
    wire wk_fall;

    ctw_wake_filter u_wake_filter (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_level(wake_s2_r),
        .o_stable(wk_stable),
        .o_rise(wk_rise),
        .o_fall(wk_fall)
    );

    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_local_wake <= 1'b0;
            o_wake_pull_up <= 1'b0;
        end else begin
            o_local_wake <= dev_low &&
                ((wk_rise && wake_en_r[`CTW_WAKE_RISE_BIT]) ||
                 (wk_fall && wake_en_r[`CTW_WAKE_FALL_BIT]));
            // pull follows the stable level to save quiescent current
            o_wake_pull_up <= wk_stable;
        end
    end
endmodule // ctw_trx_ctrl

// ==== ctw_spi_host.sv ====
module ctw_spi_host (
    input wire logic i_mclk,
    input wire logic i_sdo,
    output logic o_sck,
    output logic o_cs_n,
    output logic o_sdi
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus: deselected, clock low
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    // one 16-bit frame, msb first; shortest half period of 5 cycles beats the
    // device's two-stage pin synchroniser with margin
    task automatic xfer(input logic [6:0] a, input logic rd,
        input logic [7:0] wd, output logic [7:0] rdat);
        logic [15:0] f;
        f = {a, rd, wd};
        rdat = 8'h00;
        o_cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            tick(5);
            o_sdi <= f[i];
            tick(5);
            if (i < 8)
                rdat[i] = i_sdo;
            o_sck <= 1'b1;
            tick(5);
            o_sck <= 1'b0;
        end
        tick(6);
        o_cs_n <= 1'b1;
        o_sdi <= ~o_sdi; // released line must not keep a stale level
        tick(6);
    endtask
endmodule // ctw_spi_host

// ==== ctw_trx_ctrl_checker.sv ====
module ctw_trx_ctrl_checker (
    input wire i_mclk,
    input wire i_rst,
    input wire i_spi_cs_n,
    input wire [2:0] i_dev_mode,
    input wire i_wake_pin,
    input wire o_trx_tx_en,
    input wire o_trx_bias_stby,
    input wire o_fd_frame_ignore,
    input wire o_selective_wake_enable,
    input wire o_selwake_config_valid,
    input wire o_local_wake,
    input wire o_wake_pull_up
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    logic [11:0] pin_age_r, acc_age_r;
    logic pin_q_r, acc_q_r;
    // cycle ages of the raw wake pin and of the accepted level
    always @(posedge i_mclk) begin
        pin_q_r <= i_wake_pin;
        acc_q_r <= o_wake_pull_up;
        if (i_rst || pin_q_r != i_wake_pin)
            pin_age_r <= 12'h000;
        else if (pin_age_r != 12'hFFF)
            pin_age_r <= pin_age_r + 12'h001;
        if (i_rst || acc_q_r != o_wake_pull_up)
            acc_age_r <= 12'h000;
        else if (acc_age_r != 12'hFFF)
            acc_age_r <= acc_age_r + 12'h001;
    end
    sequence s_off_normal;
        (i_dev_mode != 3'h7) [*3];
    endsequence
    a_ctrl_reset_vals: assert property (disable iff (1'b0)
        i_rst |=> o_fd_frame_ignore && !o_selective_wake_enable
        && !o_selwake_config_valid) else $error("bad reset value");
    a_cfg_by_host: assert property ($changed(o_selwake_config_valid)
        |-> !$past(i_spi_cs_n, 2)) else $error("cfg valid moved alone");
    a_selwake_by_host: assert property (
        $changed(o_selective_wake_enable) |-> !$past(i_spi_cs_n, 2))
        else $error("selective wake moved alone");
    a_bias_off_normal: assert property (s_off_normal |->
        o_trx_bias_stby && !o_trx_tx_en) else $error("not biased");
    a_tx_needs_normal: assert property (o_trx_tx_en |->
        $past(i_dev_mode) == 3'h7) else $error("tx outside normal");
    a_wake_low_modes: assert property (o_local_wake |->
        i_dev_mode inside {3'h4, 3'h1}) else $error("wake in wrong mode");
    a_wake_settled: assert property ($changed(o_wake_pull_up) |->
        pin_age_r > 12'd2490) else $error("wake level not settled");
    a_wake_on_edge: assert property (o_local_wake |->
        $changed(o_wake_pull_up) || acc_age_r < 12'd4)
        else $error("wake pulse without accepted edge");
endmodule // ctw_trx_ctrl_checker
bind ctw_trx_ctrl ctw_trx_ctrl_checker i_ctw_trx_ctrl_checker (.i_mclk,
    .i_rst, .i_spi_cs_n, .i_dev_mode, .i_wake_pin, .o_trx_tx_en,
    .o_trx_bias_stby, .o_fd_frame_ignore, .o_selective_wake_enable,
    .o_selwake_config_valid, .o_local_wake, .o_wake_pull_up);

// ==== can_trx_control_status_wake_tb_top.sv ====
module can_trx_control_status_wake_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_mclk, i_rst, sck, cs_n, sdi, sdo, evt_en, wake;
    logic tx, rx, bias, fd, sw, cfg, lw, pu, oe;
    logic [11:0] trx_e;
    logic [6:0] pn_a;
    logic [2:0] dev;
    logic [12:0] st;
    logic [7:0] wd, dd;
    logic [31:0] r32;
    int seed, bad_count, n_compared, cyc;
    ctw_spi_host i_ctw_spi_host (.i_mclk, .i_sdo(sdo), .o_sck(sck),
        .o_cs_n(cs_n), .o_sdi(sdi));
    ctw_trx_ctrl i_ctw_trx_ctrl (.i_mclk, .i_rst, .i_spi_sck(sck),
        .i_spi_cs_n(cs_n), .i_spi_sdi(sdi), .i_dev_mode(dev),
        .i_rx_clamp_evt_en(evt_en), .i_tx_ready(st[12]),
        .i_osc_ok(st[11]), .i_bus_silent(st[10]), .i_vcc_uv(st[9]),
        .i_txd_timeout(st[8]), .i_bus_dom_timeout(st[7]),
        .i_bus_short(st[6]), .i_rx_clamp_det(st[5]),
        .i_rxd_dominant(st[4]), .i_frame_err_wake(st[3]),
        .i_osc_fail(st[2]), .i_vio_ok(st[1]), .i_txd_low(st[0]),
        .i_wake_pin(wake), .o_spi_sdo(sdo), .o_spi_sdo_oe(oe),
        .o_trx_tx_en(tx), .o_trx_rx_en(rx), .o_trx_bias_stby(bias),
        .o_fd_frame_ignore(fd), .o_selective_wake_enable(sw),
        .o_selwake_config_valid(cfg), .o_local_wake(lw),
        .o_wake_pull_up(pu));
    // free-running 50 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    // hang guard sized well above the planned traffic
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            stop_test();
        end
    end
    function automatic logic [7:0] stat_exp(logic [12:0] s, logic c);
        return {s[12], s[3] | ~c | s[2], c, s[11], s[10], 1'b0, s[9], s[8]};
    endfunction
    task automatic stop_test;
        if (bad_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_ctw_spi_host.xfer(a, 1'b0, d, q);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] q;
        i_ctw_spi_host.xfer(a, 1'b1, 8'h00, q);
        chk("register read", q, e);
    endtask
    // transceiver steering seen after the mode request settles
    task automatic trx(input logic [2:0] e);
        repeat (10) @(posedge i_mclk);
        chk("trx steering", {5'h00, tx, rx, bias}, {5'h00, e});
    endtask
    // counts local wake pulses over more than one settle time
    task automatic watch(input int e);
        int p;
        p = 0;
        repeat (3000) begin
            @(posedge i_mclk);
            #1;
            if (lw === 1'b1)
                p++;
        end
        chk("wake pulses", p[7:0], e[7:0]);
    endtask
    // main sequence
    initial begin
        seed = 72160;
        i_rst = 1'b1;
        dev = 3'h7;
        evt_en = 1'b0;
        st = 13'h0000;
        wake = 1'b0;
        repeat (12) @(posedge i_mclk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_mclk);
        chk("sdo enable idle", {7'h00, oe}, 8'h00);
        rd(7'h20, 8'h41);
        rd(7'h35, 8'h00);
        rd(7'h10, 8'h00);
        for (int k = 0; k < 6; k++) begin
            r32 = $random(seed);
            wd = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : r32[20:13];
            st <= r32[12:0];
            wr(7'h20, wd);
            wr(7'h22, ~wd);
            rd(7'h20, wd & 8'h73);
            chk("ctrl pins", {1'b0, fd, cfg, sw, 4'h0}, wd & 8'h70);
            rd(7'h22, stat_exp(st, wd[5]));
            rd(7'h33, {6'h00, st[7:6]});
        end
        // every selwake configuration range end clears config-valid
        for (int j = 0; j < 4; j++) begin
            pn_a = j[1] ? (j[0] ? 7'h6F : 7'h68) : (j[0] ? 7'h2F : 7'h26);
            wr(7'h20, 8'h71);
            wr(pn_a, 8'h5A);
            rd(7'h20, 8'h51);
        end
        st <= 13'h0022;
        evt_en <= 1'b1;
        rd(7'h35, 8'h01);
        st[5] <= 1'b0;
        rd(7'h35, 8'h01);
        st[4] <= 1'b1;
        rd(7'h35, 8'h00);
        st <= 13'h0202;
        // {tx, rx, bias} for modes 00, 01 with undervoltage, 10, 11
        trx_e = 12'b001_001_110_010;
        for (int m = 0; m < 4; m++) begin
            wr(7'h40 | m[6:0], 8'h00);
            wr(7'h20, 8'h40 | m[7:0]);
            trx(trx_e[(3 - m) * 3 +: 3]);
            rd(7'h20, 8'h40 | m[7:0]);
        end
        st <= 13'h0003;
        wr(7'h20, 8'h40);
        wr(7'h20, 8'h41);
        trx(3'b010);
        st[0] <= 1'b0;
        trx(3'b110);
        dev <= 3'h4;
        wr(7'h4C, 8'h03);
        rd(7'h4C, 8'h03);
        wake <= 1'b1;
        repeat (100) @(posedge i_mclk);
        wake <= 1'b0;
        watch(0);
        wake <= 1'b1;
        watch(1);
        chk("pull level", {7'h00, pu}, 8'h01);
        rd(7'h4B, 8'h02);
        wr(7'h4C, 8'h01);
        dev <= 3'h1;
        wake <= 1'b0;
        watch(1);
        wake <= 1'b1;
        watch(0);
        wr(7'h4C, 8'h00);
        rd(7'h4B, 8'h00);
        dev <= 3'h7;
        rd(7'h4B, 8'h02);
        stop_test();
    end
endmodule // can_trx_control_status_wake_tb_top
